/* core/jk_sequencer.sv */
// fuse-programmed mealy sequencer: j-k state and output registers, diagnostics
`timescale 1ns/1ns
`default_nettype none
`include "seq_cfg.svh"
module jk_sequencer (
    // ==========================================================
    // clock, reset, freeze
    input  wire logic                                           core_clk,
    input  wire logic                                           rst_n,
    input  wire logic                                           clk_en,
    // ==========================================================
    // device pins, inputs all asynchronous to core_clk
    input  wire logic                                           primary_clock,
    input  wire logic [`SEQ_NUM_IN-1:0]                         logic_inputs,
    input  wire logic                                           init_oe_pin,
    input  wire logic                                           state_view_select,
    input  wire logic                                           state_jam_select,
    input  wire logic                                           output_jam_select,
    input  wire logic [`SEQ_REG_W-1:0]                          output_pins_in,
    output logic      [`SEQ_REG_W-1:0]                          output_pins_out,
    output logic      [`SEQ_REG_W-1:0]                          output_pins_oe,
    // ==========================================================
    // static fuse map
    input  wire logic [`SEQ_NUM_TERMS-1:0][`SEQ_TERM_CFG_W-1:0] term_cfg,
    input  wire logic [1:0][`SEQ_NUM_TERMS-1:0]                 comp_conn,
    input  wire logic [`SEQ_NUM_JK-1:0][`SEQ_NUM_TERMS-1:0]     j_conn,
    input  wire logic [`SEQ_NUM_JK-1:0][`SEQ_NUM_TERMS-1:0]     k_conn,
    input  wire logic [`SEQ_NUM_JK-1:0]                         init_value,
    input  wire logic                                           pin_is_init,
    input  wire logic                                           dual_clock,
    // ==========================================================
    // register observation
    output logic      [`SEQ_REG_W-1:0]                          state_bits,
    output logic      [`SEQ_REG_W-1:0]                          output_reg_bits,
    output logic      [1:0]                                     complement_terms
);

    seq_pkg::seq_state_t state_r;
    seq_pkg::seq_state_t state_nxt;
    seq_pkg::diag_mode_t mode;

    logic [`SEQ_SYNC_W-1:0]    sync_v;
    logic [`SEQ_NUM_IN-1:0]    ins_s;
    logic [`SEQ_REG_W-1:0]     pins_s;
    logic                      prim_s;
    logic                      sec_s;
    logic                      init_s;
    logic                      init_active;
    logic                      oe_off;
    logic                      prim_rise;
    logic                      prim_fall;
    logic                      sec_rise;
    logic                      sec_fall;
    logic                      lo_upd;
    logic                      hi_upd;
    logic [`SEQ_NUM_TERMS-1:0] terms;
    logic [`SEQ_NUM_JK-1:0]    j_in;
    logic [`SEQ_NUM_JK-1:0]    k_in;
    logic [`SEQ_NUM_JK-1:0]    cur_bits;
    logic [`SEQ_NUM_JK-1:0]    nxt_bits;
    logic [`SEQ_NUM_JK-1:0]    jam_bits;
    logic [`SEQ_NUM_JK-1:0]    jam_mask;

    // j-k flop next value on a rising edge
    function automatic logic jk_next(
        input logic q,
        input logic j,
        input logic k
    );
        logic r;
        case ({j, k})
            2'b00:   r = q;
            2'b01:   r = 1'b0;
            2'b10:   r = 1'b1;
            default: r = ~q;
        endcase
        return r;
    endfunction : jk_next

    // ==========================================================
    // pin synchronisers, every pin read only after two flops
    pin_sync u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in ({output_pins_in, output_jam_select, state_jam_select,
                    state_view_select, init_oe_pin, primary_clock,
                    logic_inputs}),
        .sync_out (sync_v)
    );

    assign ins_s  = sync_v[`SEQ_NUM_IN-1:0];
    assign prim_s = sync_v[`SEQ_SY_PCLK];
    assign init_s = sync_v[`SEQ_SY_INIT];
    assign pins_s = sync_v[`SEQ_SY_PIN_LO +: `SEQ_REG_W];

    // ==========================================================
    // shared pin: init when the option bit is set, else active-low enable
    assign init_active = pin_is_init & init_s;
    assign oe_off      = ~pin_is_init & init_s;

    // ==========================================================
    // fixed priority: state jam, then output jam, then state view
    always_comb begin
        if (sync_v[`SEQ_SY_SJAM]) begin
            mode = seq_pkg::MODE_SJAM;
        end else if (sync_v[`SEQ_SY_OJAM]) begin
            mode = seq_pkg::MODE_OJAM;
        end else if (sync_v[`SEQ_SY_VIEW]) begin
            mode = seq_pkg::MODE_VIEW;
        end else begin
            mode = seq_pkg::MODE_LOGIC;
        end
    end

    // ==========================================================
    // clock edges; the second clock shares a logic input pin
    assign sec_s     = dual_clock ? ins_s[`SEQ_SHARED_IN] : prim_s;
    assign prim_rise = prim_s & ~state_r.prim_d;
    assign prim_fall = ~prim_s & state_r.prim_d;
    assign sec_rise  = sec_s & ~state_r.sec_d;
    assign sec_fall  = ~sec_s & state_r.sec_d;

    // a rise counts only once a fall has been seen since reset or init
    assign lo_upd = prim_rise & state_r.armed_p;
    assign hi_upd = sec_rise & state_r.armed_s;

    // ==========================================================
    // and-array with complement terms
    term_array u_terms (
        .ins        (ins_s),
        .st         (state_r.state_bits),
        .term_cfg   (term_cfg),
        .comp_conn  (comp_conn),
        .comp_terms (complement_terms),
        .terms      (terms)
    );

    // ==========================================================
    // or-array: any subset of terms onto each J and K
    always_comb begin
        for (int b = 0; b < `SEQ_NUM_JK; b++) begin
            j_in[b] = |(terms & j_conn[b]);
            k_in[b] = |(terms & k_conn[b]);
        end
    end

    // ==========================================================
    // jam data and which register a jam targets
    always_comb begin
        jam_bits = {pins_s, pins_s};
        jam_mask = '0;
        case (mode)
            seq_pkg::MODE_SJAM: jam_mask = {8'h00, 8'hFF};
            seq_pkg::MODE_OJAM: jam_mask = {8'hFF, 8'h00};
            default:            jam_mask = '0;
        endcase
    end

    // ==========================================================
    // per-bit update: low half of each register on the primary clock, high half on second
    always_comb begin
        cur_bits = {state_r.out_bits, state_r.state_bits};
        nxt_bits = cur_bits;
        for (int b = 0; b < `SEQ_NUM_JK; b++) begin
            if ((b % `SEQ_REG_W) < `SEQ_HALF ? lo_upd : hi_upd) begin
                if (mode == seq_pkg::MODE_SJAM || mode == seq_pkg::MODE_OJAM) begin
                    // the register not selected keeps its value
                    nxt_bits[b] = jam_mask[b] ? jam_bits[b] : cur_bits[b];
                end else begin
                    nxt_bits[b] = jk_next(cur_bits[b], j_in[b], k_in[b]);
                end
            end
        end
    end

    // ==========================================================
    // next state: init wins over every clock edge
    always_comb begin
        state_nxt        = state_r;
        state_nxt.prim_d = prim_s;
        state_nxt.sec_d  = sec_s;
        if (init_active) begin
            // force configured values and forget any fall seen so far
            state_nxt.state_bits = init_value[`SEQ_REG_W-1:0];
            state_nxt.out_bits   = init_value[`SEQ_NUM_JK-1:`SEQ_REG_W];
            state_nxt.armed_p    = 1'b0;
            state_nxt.armed_s    = 1'b0;
        end else begin
            state_nxt.state_bits = nxt_bits[`SEQ_REG_W-1:0];
            state_nxt.out_bits   = nxt_bits[`SEQ_NUM_JK-1:`SEQ_REG_W];
            state_nxt.armed_p    = state_r.armed_p | prim_fall;
            state_nxt.armed_s    = state_r.armed_s | sec_fall;
        end
        // pins follow the new register contents in the same edge
        if (mode == seq_pkg::MODE_VIEW) begin
            state_nxt.pin_dout = state_nxt.state_bits;
        end else begin
            state_nxt.pin_dout = state_nxt.out_bits;
        end
        if (mode == seq_pkg::MODE_SJAM || mode == seq_pkg::MODE_OJAM) begin
            state_nxt.pin_oe = `SEQ_PIN_FLOAT;
        end else if (oe_off) begin
            state_nxt.pin_oe = `SEQ_PIN_FLOAT;
        end else begin
            state_nxt.pin_oe = `SEQ_PIN_DRIVE;
        end
    end

    // ==========================================================
    // all state in one register; power-up sets register, pin and enable bits to one, edge and arm flags to zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r.state_bits <= `SEQ_PWRUP_REG;
            state_r.out_bits   <= `SEQ_PWRUP_REG;
            state_r.prim_d     <= 1'b0;
            state_r.sec_d      <= 1'b0;
            state_r.armed_p    <= 1'b0;
            state_r.armed_s    <= 1'b0;
            state_r.pin_dout   <= `SEQ_PWRUP_REG;
            state_r.pin_oe     <= `SEQ_PIN_DRIVE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // outputs, all from flops except complement_terms
    assign output_pins_out = state_r.pin_dout;
    assign output_pins_oe  = state_r.pin_oe;
    assign state_bits      = state_r.state_bits;
    assign output_reg_bits = state_r.out_bits;

endmodule : jk_sequencer
`default_nettype wire

/* core/pin_sync.sv */
// two-stage synchroniser for every pin sampled by the sequencer
`timescale 1ns/1ns
`default_nettype none
`include "seq_cfg.svh"
module pin_sync (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    input  wire logic [`SEQ_SYNC_W-1:0] async_in,
    output logic      [`SEQ_SYNC_W-1:0] sync_out
);
    seq_pkg::sync_state_t state_r;
    seq_pkg::sync_state_t state_nxt;

    // ==========================================================
    // stage1 feeds only stage2, nothing else looks at it
    always_comb begin
        state_nxt        = state_r;
        state_nxt.stage1 = async_in;
        state_nxt.stage2 = state_r.stage1;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= {`SEQ_SYNC_RST, `SEQ_SYNC_RST};
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign sync_out = state_r.stage2;

endmodule : pin_sync
`default_nettype wire

/* core/seq_cfg.svh */
// constants and counts for the fuse-programmed j-k sequencer
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

// ==========================================================
// array sizes
`define SEQ_NUM_TERMS 64
`define SEQ_NUM_IN 16
`define SEQ_REG_W 8
`define SEQ_NUM_JK 16
`define SEQ_NUM_VARS 26
`define SEQ_TERM_CFG_W 52
`define SEQ_COMP_LO 24
`define SEQ_HALF 4
`define SEQ_SHARED_IN 5

// ==========================================================
// per-variable link codes
`define SEQ_CODE_OFF 2'h0
`define SEQ_CODE_TRUE 2'h1
`define SEQ_CODE_COMP 2'h2
`define SEQ_CODE_DC 2'h3

// ==========================================================
// reset values and pin drive patterns
`define SEQ_PWRUP_REG 8'hFF
`define SEQ_PIN_DRIVE 8'hFF
`define SEQ_PIN_FLOAT 8'h00

// ==========================================================
// synchroniser vector layout
`define SEQ_SYNC_W 29
`define SEQ_SYNC_RST 29'h0
`define SEQ_SY_PCLK 16
`define SEQ_SY_INIT 17
`define SEQ_SY_VIEW 18
`define SEQ_SY_SJAM 19
`define SEQ_SY_OJAM 20
`define SEQ_SY_PIN_LO 21

`endif

/* core/seq_pkg.sv */
// types shared by the sequencer modules
`include "seq_cfg.svh"
package seq_pkg;

    // ==========================================================
    // diagnostic mode, resolved from the select inputs
    typedef enum logic [1:0] {
        MODE_LOGIC = 2'b00,
        MODE_VIEW  = 2'b01,
        MODE_SJAM  = 2'b10,
        MODE_OJAM  = 2'b11
    } diag_mode_t;

    // ==========================================================
    // synchroniser state
    typedef struct packed {
        logic [`SEQ_SYNC_W-1:0] stage1;
        logic [`SEQ_SYNC_W-1:0] stage2;
    } sync_state_t;

    // ==========================================================
    // sequencer core state
    typedef struct packed {
        logic [`SEQ_REG_W-1:0] state_bits;
        logic [`SEQ_REG_W-1:0] out_bits;
        logic                  prim_d;
        logic                  sec_d;
        logic                  armed_p;
        logic                  armed_s;
        logic [`SEQ_REG_W-1:0] pin_dout;
        logic [`SEQ_REG_W-1:0] pin_oe;
    } seq_state_t;

endpackage : seq_pkg

/* core/term_array.sv */
// and-array: 64 product terms in two passes through the complement terms
`timescale 1ns/1ns
`default_nettype none
`include "seq_cfg.svh"
module term_array (
    input  wire logic [`SEQ_NUM_IN-1:0]                          ins,
    input  wire logic [`SEQ_REG_W-1:0]                           st,
    input  wire logic [`SEQ_NUM_TERMS-1:0][`SEQ_TERM_CFG_W-1:0]  term_cfg,
    input  wire logic [1:0][`SEQ_NUM_TERMS-1:0]                  comp_conn,
    output logic      [1:0]                                      comp_terms,
    output logic      [`SEQ_NUM_TERMS-1:0]                       terms
);
    logic [`SEQ_NUM_TERMS-1:0] pass1;

    // one product term; complement variables skipped on the first pass
    function automatic logic term_hit(
        input logic [`SEQ_TERM_CFG_W-1:0] cfg,
        input logic [`SEQ_NUM_VARS-1:0]   vars,
        input logic                       use_comp
    );
        logic       hit;
        logic [1:0] code;
        hit = 1'b1;
        for (int v = 0; v < `SEQ_NUM_VARS; v++) begin
            code = cfg[2*v +: 2];
            if (v >= `SEQ_COMP_LO && !use_comp) begin
                code = `SEQ_CODE_DC;
            end
            case (code)
                `SEQ_CODE_OFF:  hit = 1'b0;
                `SEQ_CODE_TRUE: hit = hit & vars[v];
                `SEQ_CODE_COMP: hit = hit & ~vars[v];
                default:        hit = hit;
            endcase
        end
        return hit;
    endfunction : term_hit

    // ==========================================================
    // the split into two passes keeps the complement path free of loops
    always_comb begin
        for (int t = 0; t < `SEQ_NUM_TERMS; t++) begin
            pass1[t] = term_hit(term_cfg[t], {2'h0, st, ins}, 1'b0);
        end
        for (int k = 0; k < 2; k++) begin
            comp_terms[k] = ~|(pass1 & comp_conn[k]);
        end
        for (int t = 0; t < `SEQ_NUM_TERMS; t++) begin
            terms[t] = term_hit(term_cfg[t], {comp_terms, st, ins}, 1'b1);
        end
    end

endmodule : term_array
`default_nettype wire

/* testbench/seq_props.sv */
// concurrent checks on the sequencer pins and registers
`timescale 1ns/1ns
`default_nettype none
module seq_props (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        primary_clock,
    input wire logic [15:0] logic_inputs,
    input wire logic        init_oe_pin,
    input wire logic        state_view_select,
    input wire logic        state_jam_select,
    input wire logic        output_jam_select,
    input wire logic [7:0]  output_pins_out,
    input wire logic [7:0]  output_pins_oe,
    input wire logic [15:0] init_value,
    input wire logic        pin_is_init,
    input wire logic [7:0]  state_bits,
    input wire logic [7:0]  output_reg_bits
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] idle_r;
    // ===========================================================
    // cycles since a clock rise or init change; saturates, so it is
    // coarse but cannot wrap into a false quiet window
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_r <= 3'h0;
        end else if ($rose(primary_clock) || $rose(logic_inputs[5]) || $changed(init_oe_pin)) begin
            idle_r <= 3'h0;
        end else if (idle_r != 3'h7) begin
            idle_r <= idle_r + 3'h1;
        end
    end
    // ===========================================================
    // properties
    property p_pwrup;
        $rose(rst_n) |-> state_bits == 8'hFF && output_reg_bits == 8'hFF;
    endproperty
    a_pwrup: assert property (p_pwrup)
        else $error("registers not all ones after reset");
    property p_init;
        (pin_is_init && init_oe_pin) [*5] |->
            {output_reg_bits, state_bits} == init_value && output_pins_out == init_value[15:8];
    endproperty
    a_init: assert property (p_init)
        else $error("init value not applied");
    property p_hold;
        idle_r == 3'h7 |-> $stable(state_bits) && $stable(output_reg_bits);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed without a clock rise");
    property p_oe_off;
        (!pin_is_init && init_oe_pin) [*4] |-> output_pins_oe == 8'h00;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("pins driven while enable high");
    property p_oe_on;
        ((pin_is_init || !init_oe_pin) && !state_jam_select && !output_jam_select) [*4]
            |-> output_pins_oe == 8'hFF;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("pins not driven");
    property p_view;
        (state_view_select && !state_jam_select && !output_jam_select) [*4]
            |-> output_pins_out == state_bits;
    endproperty
    a_view: assert property (p_view)
        else $error("pins do not show state register");
    property p_out;
        (!state_view_select && !state_jam_select && !output_jam_select) [*4]
            |-> output_pins_out == output_reg_bits;
    endproperty
    a_out: assert property (p_out)
        else $error("pins do not show output register");
    property p_jam_oe;
        (state_jam_select || output_jam_select) [*4] |-> output_pins_oe == 8'h00;
    endproperty
    a_jam_oe: assert property (p_jam_oe)
        else $error("pins still driven in jam mode");
    c_jam: cover property (state_jam_select && $rose(primary_clock));
    c_view: cover property (state_view_select [*4]);
    c_init: cover property ((pin_is_init && init_oe_pin) [*5]);
endmodule : seq_props
bind jk_sequencer seq_props i_seq_props (.core_clk, .rst_n, .primary_clock, .logic_inputs,
    .init_oe_pin, .state_view_select, .state_jam_select, .output_jam_select, .output_pins_out,
    .output_pins_oe, .init_value, .pin_is_init, .state_bits, .output_reg_bits);
`default_nettype wire

/* testbench/sys_driver.sv */
// model of the system logic driving device clocks, logic inputs and init pin
`timescale 1ns/1ns
`default_nettype none
module sys_driver (
    input  wire logic        core_clk,
    output var  logic        primary_clock,
    output var  logic [15:0] logic_inputs,
    output var  logic        init_oe_pin
);
    // ===========================================================
    // clock starts high so the first rise after power-up is unarmed
    initial begin
        primary_clock = 1'b1;
        logic_inputs = 16'h0000;
        init_oe_pin = 1'b0;
    end
    // move one device clock; four cycles of hold keep inputs and jam data past the rise
    task automatic clk_to(input logic sec, input logic lvl);
        @(negedge core_clk);
        if (sec) begin
            logic_inputs[5] = lvl;
        end else begin
            primary_clock = lvl;
        end
        repeat (4) @(negedge core_clk);
    endtask : clk_to
    // one full fall then rise
    task automatic pulse(input logic sec);
        clk_to(sec, 1'b0);
        clk_to(sec, 1'b1);
    endtask : pulse
    // bit 5 stays with the clock task
    task automatic set_in(input logic [15:0] v);
        @(negedge core_clk);
        logic_inputs = {v[15:6], logic_inputs[5], v[4:0]};
    endtask : set_in
    task automatic set_init(input logic lvl);
        @(negedge core_clk);
        init_oe_pin = lvl;
    endtask : set_init
endmodule : sys_driver
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the j-k sequencer
`timescale 1ns/1ns
`default_nettype none
`include "seq_cfg.svh"
module testbench;
    typedef struct packed {
        logic [15:0] ins;
        logic [7:0]  st;
        logic [7:0]  outr;
        logic [1:0]  ct;
    } row_t;
    logic core_clk, rst_n, clk_en, primary_clock, init_oe_pin, pin_is_init, dual_clock;
    logic state_view_select, state_jam_select, output_jam_select, jam_en;
    logic [15:0] logic_inputs, init_value;
    logic [7:0] output_pins_in, output_pins_out, output_pins_oe, jam_data;
    logic [7:0] state_bits, output_reg_bits;
    logic [1:0] complement_terms;
    logic [63:0][51:0] term_cfg;
    logic [1:0][63:0] comp_conn;
    logic [15:0][63:0] j_conn, k_conn;
    int miscompares, num_checks;
    // hold, toggle, set/else-clear, clear, unprogrammed-term cases
    row_t rows [9] = '{'{16'h0000, 8'h00, 8'h00, 2'h3}, '{16'h0002, 8'hFF, 8'hFF, 2'h3},
        '{16'h0008, 8'hFF, 8'h00, 2'h3}, '{16'h0002, 8'h00, 8'hFF, 2'h3},
        '{16'h0004, 8'h00, 8'h00, 2'h1}, '{16'h0009, 8'hFF, 8'hFF, 2'h2},
        '{16'h000A, 8'h00, 8'h00, 2'h3}, '{16'h0001, 8'hFF, 8'hFF, 2'h2},
        '{16'h0000, 8'hFF, 8'hFF, 2'h3}};
    // ===========================================================
    // pin level: device drive, else jam data, else a floating pattern
    assign output_pins_in = (output_pins_oe & output_pins_out)
        | (~output_pins_oe & (jam_en ? jam_data : ~output_pins_out));
    jk_sequencer i_jk_sequencer (.core_clk, .rst_n, .clk_en, .primary_clock, .logic_inputs,
        .init_oe_pin, .state_view_select, .state_jam_select, .output_jam_select,
        .output_pins_in, .output_pins_out, .output_pins_oe, .term_cfg, .comp_conn, .j_conn,
        .k_conn, .init_value, .pin_is_init, .dual_clock, .state_bits, .output_reg_bits,
        .complement_terms);
    sys_driver i_sys_driver (.core_clk, .primary_clock, .logic_inputs, .init_oe_pin);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // ===========================================================
    // fuse map; input 5 stays don't care in terms 0 to 5, complement links too except in term 4
    initial begin
        term_cfg = '0;
        for (int t = 0; t < 6; t++) begin
            term_cfg[t] = {26{`SEQ_CODE_DC}};
        end
        term_cfg[0][3:0] = {`SEQ_CODE_COMP, `SEQ_CODE_TRUE};
        term_cfg[1][5:0] = {`SEQ_CODE_TRUE, `SEQ_CODE_COMP, `SEQ_CODE_COMP};
        term_cfg[2][3:2] = `SEQ_CODE_TRUE;
        term_cfg[3][3:2] = `SEQ_CODE_TRUE;
        term_cfg[4][49:48] = `SEQ_CODE_TRUE;
        term_cfg[4][7:6] = `SEQ_CODE_TRUE;
        term_cfg[5][7:6] = `SEQ_CODE_TRUE;
        term_cfg[5][13:12] = `SEQ_CODE_OFF;
        comp_conn = {64'h2, 64'h1};
        for (int b = 0; b < 16; b++) begin
            j_conn[b] = (b < 8) ? 64'h5 : 64'h9;
            k_conn[b] = (b < 8) ? 64'h26 : 64'h1A;
        end
    end
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp2(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: terms %b expected %b", $time, got, exp);
        end
    endtask : cmp2
    // jam data onto the pins; selects held until after both clock rises
    task automatic jam(input logic s, input logic o, input logic [7:0] d);
        @(negedge core_clk);
        state_jam_select = s;
        output_jam_select = o;
        jam_en = 1'b1;
        jam_data = d;
        repeat (4) @(negedge core_clk);
        cmp8(output_pins_oe, 8'h00);
        i_sys_driver.pulse(1'b0);
        i_sys_driver.pulse(1'b1);
        state_jam_select = 1'b0;
        output_jam_select = 1'b0;
        jam_en = 1'b0;
    endtask : jam
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        final_report();
    end
    // ===========================================================
    // main sequence
    initial begin
        {rst_n, state_view_select, state_jam_select, output_jam_select, jam_en} = 5'h00;
        {clk_en, pin_is_init, dual_clock, jam_data, init_value} = {3'h6, 8'h00, 16'hA53C};
        miscompares = 0;
        num_checks = 0;
        repeat (3) @(negedge core_clk);
        cmp8(state_bits, 8'hFF);
        cmp8(output_pins_out, 8'hFF);
        @(negedge core_clk);
        rst_n = 1'b1;
        i_sys_driver.set_in(16'h0002);
        repeat (6) @(negedge core_clk);
        cmp8(state_bits, 8'hFF);
        i_sys_driver.pulse(1'b0);
        cmp8(output_reg_bits, 8'h00);
        foreach (rows[i]) begin
            i_sys_driver.set_in(rows[i].ins);
            i_sys_driver.pulse(1'b0);
            cmp8(state_bits, rows[i].st);
            cmp8(output_reg_bits, rows[i].outr);
            cmp8(output_pins_out, rows[i].outr);
            cmp2(complement_terms, rows[i].ct);
        end
        i_sys_driver.set_in(16'h0002);
        i_sys_driver.set_init(1'b1);
        repeat (5) @(negedge core_clk);
        cmp8(state_bits, 8'h3C);
        cmp8(output_pins_out, 8'hA5);
        i_sys_driver.pulse(1'b0);
        cmp8(state_bits, 8'h3C);
        i_sys_driver.clk_to(1'b0, 1'b0);
        i_sys_driver.set_init(1'b0);
        i_sys_driver.clk_to(1'b0, 1'b1);
        cmp8(state_bits, 8'h3C);
        i_sys_driver.pulse(1'b0);
        cmp8(state_bits, 8'hC3);
        cmp8(output_reg_bits, 8'h5A);
        // second power-up: enable pin and split clocks
        rst_n = 1'b0;
        pin_is_init = 1'b0;
        dual_clock = 1'b1;
        // an all-zero init pattern must never show while the pin is an enable
        init_value = 16'h0000;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        i_sys_driver.set_init(1'b1);
        repeat (4) @(negedge core_clk);
        cmp8(output_pins_oe, 8'h00);
        cmp8(state_bits, 8'hFF);
        i_sys_driver.set_init(1'b0);
        repeat (4) @(negedge core_clk);
        cmp8(output_pins_oe, 8'hFF);
        i_sys_driver.pulse(1'b0);
        cmp8(state_bits, 8'hF0);
        i_sys_driver.clk_to(1'b1, 1'b1);
        cmp8(output_reg_bits, 8'hF0);
        i_sys_driver.pulse(1'b1);
        cmp8(output_reg_bits, 8'h00);
        i_sys_driver.set_in(16'h0000);
        jam(1'b1, 1'b0, 8'h5A);
        cmp8(state_bits, 8'h5A);
        cmp8(output_reg_bits, 8'h00);
        jam(1'b0, 1'b1, 8'h3C);
        cmp8(output_reg_bits, 8'h3C);
        jam(1'b1, 1'b1, 8'h81);
        cmp8(state_bits, 8'h81);
        cmp8(output_reg_bits, 8'h3C);
        state_view_select = 1'b1;
        repeat (4) @(negedge core_clk);
        cmp8(output_pins_out, 8'h81);
        state_view_select = 1'b0;
        repeat (4) @(negedge core_clk);
        cmp8(output_pins_out, 8'h3C);
        // freeze: a full device clock pulse while clk_en is low must be lost
        i_sys_driver.set_in(16'h0002);
        repeat (3) @(negedge core_clk);
        clk_en = 1'b0;
        i_sys_driver.pulse(1'b0);
        clk_en = 1'b1;
        repeat (4) @(negedge core_clk);
        cmp8(state_bits, 8'h81);
        cmp8(output_reg_bits, 8'h3C);
        i_sys_driver.pulse(1'b0);
        cmp8(state_bits, 8'h8E);
        cmp8(output_reg_bits, 8'h33);
        final_report();
    end
endmodule : testbench
`default_nettype wire
